// >>> verification/cml_host_model.sv
`timescale 1ns/10ps
module cml_host_model
  import cml_pkg::*;
(
  input wire logic image_sel_i,
  output logic [7:0] nv_bias_o,
  output logic [7:0] nv_cycle_count_o,
  output logic [15:0] nv_full40_o,
  output logic [9:0] nv_ae_frac_o,
  output logic [7:0] nv_slope_full_o [N_SEG],
  output logic [7:0] nv_slope_ae_o [N_SEG],
  output logic [7:0] nv_slope_se_o [N_SEG],
  output logic [7:0] nv_bp12_o,
  output logic [7:0] nv_bp23_o,
  output logic [7:0] nv_bp34_o,
  output logic [7:0] nv_cond_o,
  output logic [7:0] nv_full_charge_voltage_threshold_o,
  output logic [7:0] nv_vae_o,
  output logic [7:0] nv_iae_o
);
  // image 0: tiny full value so the odometer moves fast
  assign nv_bias_o = image_sel_i ? 8'h00 : 8'h10;
  assign nv_cycle_count_o = image_sel_i ? 8'h00 : 8'h05;
  assign nv_full40_o = image_sel_i ? 16'h1000 : 16'h0001;
  assign nv_ae_frac_o = 10'h200;
  assign nv_slope_full_o = '{8'h20, 8'h40, 8'h80, 8'h40};
  assign nv_slope_ae_o = '{8'h10, 8'h10, 8'h10, 8'h20};
  assign nv_slope_se_o = '{8'h08, 8'h08, 8'h08, 8'h10};
  assign nv_bp12_o = 8'hEC;
  assign nv_bp23_o = 8'h00;
  assign nv_bp34_o = 8'h14;
  assign nv_cond_o = 8'h32;
  assign nv_full_charge_voltage_threshold_o = 8'hD7;
  assign nv_vae_o = 8'h99;
  assign nv_iae_o = 8'h02;
endmodule // cml_host_model

// >>> verification/tb_cml_lookup.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_cml_lookup
  import cml_pkg::*;
;
  localparam logic [10:0] TT [6] = '{11'h140, 11'h190, 11'h0F0, 11'h0F7, 11'h050, 11'h6C0};
  localparam logic [15:0] EF [6] = '{16'h1000, 16'h1000, 16'h0F60, 16'h0F60, 16'h0D80, 16'h0A60};
  localparam logic [15:0] EA [6] = '{16'h0800, 16'h0800, 16'h0850, 16'h0850, 16'h08C8, 16'h0990};
  localparam logic [15:0] ES [6] = '{16'h0000, 16'h0000, 16'h0028, 16'h0028, 16'h0064, 16'h00C8};
  localparam logic [9:0] V1 [4] = '{10'h3FF, 10'h200, 10'h3FF, 10'h35C};
  localparam logic [9:0] V2 [4] = '{10'h3FF, 10'h200, 10'h000, 10'h35C};
  localparam logic FC [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic AV [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int failures = 0;
  int check_count = 0;
  logic core_clk_i, reset_n_i, nv_load_i, bias_wr_i, acr_wr_i, cycle_wr_i, block1_locked_i, image_sel;
  logic [7:0] nv_bias_i, nv_cycle_count_i, bias_wdata_i, cycle_wdata_i;
  logic [15:0] nv_full40_i, acr_wdata_i, current_i;
  logic [9:0] nv_ae_frac_i, first_cell_voltage_i, second_cell_voltage_i;
  logic [7:0] nv_slope_full_i [N_SEG];
  logic [7:0] nv_slope_ae_i [N_SEG];
  logic [7:0] nv_slope_se_i [N_SEG];
  logic [7:0] nv_breakpoint_seg1_seg2_i, nv_breakpoint_seg2_seg3_i, nv_breakpoint_seg3_seg4_i;
  logic [7:0] nv_sense_conductance_i, nv_full_charge_voltage_threshold_i;
  logic [7:0] nv_active_empty_voltage_i, nv_active_empty_current_i;
  logic [10:0] temp_i;
  logic loaded_o, conv_done_o, full_charge_voltage_reached_o;
  logic active_empty_voltage_reached_o, active_empty_current_reached_o;
  logic [7:0] accumulation_bias_value_o, cycle_count_o;
  logic [15:0] charge_accumulator_o, full_cap_o, active_empty_cap_o, standby_empty_cap_o;
  logic [23:0] full_abs_o;

  cml_host_model i_cml_host_model (.image_sel_i(image_sel), .nv_bias_o(nv_bias_i),
    .nv_cycle_count_o(nv_cycle_count_i), .nv_full40_o(nv_full40_i), .nv_ae_frac_o(nv_ae_frac_i),
    .nv_slope_full_o(nv_slope_full_i), .nv_slope_ae_o(nv_slope_ae_i), .nv_slope_se_o(nv_slope_se_i),
    .nv_bp12_o(nv_breakpoint_seg1_seg2_i), .nv_bp23_o(nv_breakpoint_seg2_seg3_i),
    .nv_bp34_o(nv_breakpoint_seg3_seg4_i), .nv_cond_o(nv_sense_conductance_i),
    .nv_full_charge_voltage_threshold_o(nv_full_charge_voltage_threshold_i), .nv_vae_o(nv_active_empty_voltage_i),
    .nv_iae_o(nv_active_empty_current_i));

  // short conversion period keeps the run brief
  cml_lookup #(.CONV_CYCLES(20)) i_cml_lookup (.core_clk_i, .reset_n_i, .nv_load_i, .nv_bias_i,
    .nv_cycle_count_i, .nv_full40_i, .nv_ae_frac_i, .nv_slope_full_i, .nv_slope_ae_i, .nv_slope_se_i,
    .nv_breakpoint_seg1_seg2_i, .nv_breakpoint_seg2_seg3_i, .nv_breakpoint_seg3_seg4_i,
    .nv_sense_conductance_i, .nv_full_charge_voltage_threshold_i, .nv_active_empty_voltage_i,
    .nv_active_empty_current_i, .bias_wr_i, .bias_wdata_i, .acr_wr_i, .acr_wdata_i, .cycle_wr_i,
    .cycle_wdata_i, .block1_locked_i, .current_i, .temp_i, .first_cell_voltage_i,
    .second_cell_voltage_i, .loaded_o, .conv_done_o, .accumulation_bias_value_o, .charge_accumulator_o,
    .cycle_count_o, .full_cap_o, .active_empty_cap_o, .standby_empty_cap_o, .full_abs_o,
    .full_charge_voltage_reached_o, .active_empty_voltage_reached_o, .active_empty_current_reached_o);

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task end_sim();
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // k: 0 bias, 1 accumulator, 2 odometer
  task wr(input int k, input logic [15:0] d);
    @(posedge core_clk_i);
    bias_wr_i <= (k == 0);
    acr_wr_i <= (k == 1);
    cycle_wr_i <= (k == 2);
    bias_wdata_i <= d[7:0];
    acr_wdata_i <= d;
    cycle_wdata_i <= d[7:0];
    @(posedge core_clk_i);
    bias_wr_i <= 1'b0;
    acr_wr_i <= 1'b0;
    cycle_wr_i <= 1'b0;
  endtask

  task load();
    @(posedge core_clk_i);
    nv_load_i <= 1'b1;
    @(posedge core_clk_i);
    nv_load_i <= 1'b0;
    settle(3);
  endtask

  // waits for the next accumulation pulse, bounded
  task tick();
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (conv_done_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      end_sim();
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    end_sim();
  end

  initial begin
    reset_n_i = 1'b0; nv_load_i = 1'b0; bias_wr_i = 1'b0; acr_wr_i = 1'b0; cycle_wr_i = 1'b0;
    bias_wdata_i = 8'h00; acr_wdata_i = 16'h0000; cycle_wdata_i = 8'h00; block1_locked_i = 1'b0;
    image_sel = 1'b0; current_i = 16'h0000; temp_i = 11'h140;
    first_cell_voltage_i = 10'h000; second_cell_voltage_i = 10'h000;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    settle(1);
    `CHK(loaded_o, 1'b0)
    load();
    `CHK(loaded_o, 1'b1)
    `CHK(accumulation_bias_value_o, 8'h10)
    `CHK(cycle_count_o, 8'h05)
    wr(2, 16'h00FD);
    block1_locked_i <= 1'b1;
    wr(2, 16'h0010);
    block1_locked_i <= 1'b0;
    settle(2);
    `CHK(cycle_count_o, 8'hFD)
    tick();
    @(posedge core_clk_i);
    current_i <= 16'hEFF0;
    wr(1, 16'h0100);
    // each tick drains one unit; odometer steps every two, then clamps
    for (int k = 1; k <= 6; k++) begin
      tick();
      `CHK(charge_accumulator_o, 16'h0100 - 16'(k))
      settle(2);
      if (k % 2 == 0) `CHK(cycle_count_o, ((k == 2) ? 8'hFE : 8'hFF))
    end
    wr(0, 16'h00F0);
    @(posedge core_clk_i);
    current_i <= 16'h1010;
    wr(1, 16'h0010);
    tick();
    `CHK(accumulation_bias_value_o, 8'hF0)
    `CHK(charge_accumulator_o, 16'h0011)
    wr(1, 16'hFFFF);
    tick();
    `CHK(charge_accumulator_o, 16'hFFFF)
    @(posedge core_clk_i);
    current_i <= 16'hF010;
    wr(1, 16'h0000);
    tick();
    `CHK(charge_accumulator_o, 16'h0000)
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    image_sel <= 1'b1;
    current_i <= 16'h0000;
    settle(2);
    `CHK(loaded_o, 1'b0)
    `CHK(charge_accumulator_o, 16'h0000)
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    load();
    `CHK(loaded_o, 1'b1)
    `CHK(full_abs_o, 24'h032000)
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      temp_i <= TT[i];
      settle(3);
      `CHK(full_cap_o, EF[i])
      `CHK(active_empty_cap_o, EA[i])
      `CHK(standby_empty_cap_o, ES[i])
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      first_cell_voltage_i <= V1[i];
      second_cell_voltage_i <= V2[i];
      settle(3);
      `CHK(full_charge_voltage_reached_o, FC[i])
      `CHK(active_empty_voltage_reached_o, AV[i])
    end
    @(posedge core_clk_i);
    current_i <= 16'hFF00;
    settle(3);
    `CHK(active_empty_current_reached_o, 1'b1)
    @(posedge core_clk_i);
    current_i <= 16'hFF01;
    settle(3);
    `CHK(active_empty_current_reached_o, 1'b0)
    end_sim();
  end
endmodule // tb_cml_lookup

// >>> verilog/cml_lookup.sv
// Summary of operation
// R1: each conversion cycle the bias is added to the charge accumulator.
// R2: bias is two's complement with the current measurement's bit weight.
// R3: bias is loaded from nonvolatile storage at power-up.
// R4: odometer LSB is two discharge cycles, 510 cycles at most.
// R5: odometer never wraps, it holds at maximum.
// R6: odometer host writes accepted only while parameter block 1 is unlocked.
// R7: four segments per curve; flat above +40 C; segment 4 ends at +40 C.
// R8: segments join at three breakpoints; segment 1 runs to all colder temperatures.
// R9: breakpoints are whole degrees from -128 C to +40 C.
// R10: segment slopes 0 to 15555 ppm in 61 ppm steps.
// R11: curve values recomputed at present temperature in one degree steps.
// R12: model normalised to full at +40 C, stored in accumulator units.
// R13: active-empty at +40 C is a fraction of full with 2^-10 resolution.
// R14: standby-empty at +40 C is zero and not stored.
// R15: four slopes per curve and breakpoints kept from the parameter block.
// R16: one-byte sense conductance converts capacity into absolute units.
// R17: one-byte full-charge voltage threshold in 19.5 mV units used for full detect.
// R18: host should set the charge threshold slightly below end-of-charge voltage.
// R19: host should choose active-empty current as a 3.5 s average.
// R20: active-empty voltage compared against the average of both cells.
// R21: one conversion every 3.52 s, accumulation applied at its end.
// R22: accumulator saturates at its maximum or minimum.
// R23: curve value walks from +40 C applying slope times degrees per segment.
// R24: odometer steps each two full-capacity equivalents of discharge, unless clamped.
`timescale 1ns/10ps
module cml_curve
  import cml_pkg::*;
#(
  parameter bit ADD_SLOPE = 1'b0
) (
  input wire logic [15:0] base_i,
  input wire logic [15:0] full40_i,
  input wire logic [7:0] slope_i [N_SEG],
  input wire logic signed [7:0] bp_i [N_BP],
  input wire logic signed [7:0] temp_i,
  output logic [15:0] value_o
);
  always_comb begin
    logic signed [9:0] edge_t [N_SEG+1];
    logic signed [9:0] lo;
    logic signed [9:0] span;
    logic [17:0] ssum;
    logic [33:0] prod;
    logic [20:0] wide;
    edge_t = '{default: '0};
    ssum = '0;
    lo = '0;
    span = '0;
    prod = '0;
    wide = '0;
    // R8 segment edges
    edge_t[0] = 10'(temp_i);
    for (int b = 0; b < N_BP; b++) begin
      edge_t[b+1] = 10'(bp_i[b]);
    end
    // R7 segment 4 tops at +40
    edge_t[N_SEG] = 10'(TEMP_TOP);
    // R23 slope times degrees spanned
    for (int k = 1; k <= N_SEG; k++) begin
      lo = (temp_i > edge_t[k-1]) ? 10'(temp_i) : edge_t[k-1];
      span = edge_t[k] - lo;
      if (span > 0) begin
        ssum = ssum + 18'(slope_i[k-1] * span[8:0]);
      end
    end
    // R10 one slope step is 2^-14 of full
    prod = full40_i * ssum;
    // wide enough that a steep cold delta cannot wrap past the clamp
    wide = ADD_SLOPE ? (21'(base_i) + 21'(prod[33:SLOPE_SHIFT])) : 21'(base_i);
    if (ADD_SLOPE) begin
      value_o = (wide > 21'(CAP_MAX)) ? CAP_MAX : wide[15:0];
    end else if (prod[33:SLOPE_SHIFT] > 20'(base_i)) begin
      value_o = '0;
    end else begin
      value_o = 16'(20'(base_i) - prod[33:SLOPE_SHIFT]);
    end
  end
endmodule // cml_curve

module cml_lookup
  import cml_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic nv_load_i,
  input wire logic [7:0] nv_bias_i,
  input wire logic [7:0] nv_cycle_count_i,
  input wire logic [15:0] nv_full40_i,
  input wire logic [9:0] nv_ae_frac_i,
  input wire logic [7:0] nv_slope_full_i [N_SEG],
  input wire logic [7:0] nv_slope_ae_i [N_SEG],
  input wire logic [7:0] nv_slope_se_i [N_SEG],
  input wire logic [7:0] nv_breakpoint_seg1_seg2_i,
  input wire logic [7:0] nv_breakpoint_seg2_seg3_i,
  input wire logic [7:0] nv_breakpoint_seg3_seg4_i,
  input wire logic [7:0] nv_sense_conductance_i,
  input wire logic [7:0] nv_full_charge_voltage_threshold_i,
  input wire logic [7:0] nv_active_empty_voltage_i,
  input wire logic [7:0] nv_active_empty_current_i,
  input wire logic bias_wr_i,
  input wire logic [7:0] bias_wdata_i,
  input wire logic acr_wr_i,
  input wire logic [15:0] acr_wdata_i,
  input wire logic cycle_wr_i,
  input wire logic [7:0] cycle_wdata_i,
  input wire logic block1_locked_i,
  input wire logic [15:0] current_i,
  input wire logic [10:0] temp_i,
  input wire logic [9:0] first_cell_voltage_i,
  input wire logic [9:0] second_cell_voltage_i,
  output logic loaded_o,
  output logic conv_done_o,
  output logic [7:0] accumulation_bias_value_o,
  output logic [15:0] charge_accumulator_o,
  output logic [7:0] cycle_count_o,
  output logic [15:0] full_cap_o,
  output logic [15:0] active_empty_cap_o,
  output logic [15:0] standby_empty_cap_o,
  output logic [23:0] full_abs_o,
  output logic full_charge_voltage_reached_o,
  output logic active_empty_voltage_reached_o,
  output logic active_empty_current_reached_o
);
  cml_state_t state, next_state;
  logic [31:0] conv_cnt, next_conv_cnt;
  logic tick;
  logic [7:0] bias, next_bias;
  logic [15:0] full40, next_full40;
  logic [9:0] ae_frac, next_ae_frac;
  logic [7:0] sl_full [N_SEG];
  logic [7:0] sl_ae [N_SEG];
  logic [7:0] sl_se [N_SEG];
  logic [7:0] next_sl_full [N_SEG];
  logic [7:0] next_sl_ae [N_SEG];
  logic [7:0] next_sl_se [N_SEG];
  logic signed [7:0] bp [N_BP];
  logic signed [7:0] next_bp [N_BP];
  logic [7:0] cond, next_cond, full_charge_voltage_threshold, next_full_charge_voltage_threshold, active_empty_voltage, next_vae, active_empty_current, next_iae;
  logic [27:0] acc, next_acc;
  logic [29:0] disch, next_disch;
  logic [7:0] odo, next_odo;
  logic signed [16:0] step;
  logic signed [29:0] sum_wide;
  logic odo_inc;
  logic signed [7:0] temp_deg;
  logic [15:0] ae40;
  logic [15:0] cur_full, cur_ae, cur_se;
  logic [10:0] vsum;
  logic [16:0] dis_mag;
  logic next_done, next_fv, next_av, next_ac;
  logic [23:0] next_abs;

  // configuration and conversion timing
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_bias = bias;
    next_full40 = full40;
    next_ae_frac = ae_frac;
    next_sl_full = sl_full;
    next_sl_ae = sl_ae;
    next_sl_se = sl_se;
    next_bp = bp;
    next_cond = cond;
    next_full_charge_voltage_threshold = full_charge_voltage_threshold;
    next_vae = active_empty_voltage;
    next_iae = active_empty_current;
    tick = 1'b0;
    if (state == ST_RUN) begin
      // R21 one tick per conversion period
      tick = (conv_cnt == CONV_CYCLES - 1);
      next_conv_cnt = tick ? '0 : conv_cnt + CNT_ONE;
    end
    // host write applies from the next conversion on
    if (bias_wr_i) begin
      next_bias = bias_wdata_i;
    end
    unique case (state)
      ST_WAIT_LOAD: begin
        if (nv_load_i) begin
          // R3 bias recalled from storage
          next_bias = nv_bias_i;
          // R15 curve parameters kept
          next_full40 = nv_full40_i;
          next_ae_frac = nv_ae_frac_i;
          next_sl_full = nv_slope_full_i;
          next_sl_ae = nv_slope_ae_i;
          next_sl_se = nv_slope_se_i;
          next_bp[0] = nv_breakpoint_seg1_seg2_i;
          next_bp[1] = nv_breakpoint_seg2_seg3_i;
          next_bp[2] = nv_breakpoint_seg3_seg4_i;
          next_cond = nv_sense_conductance_i;
          next_full_charge_voltage_threshold = nv_full_charge_voltage_threshold_i;
          next_vae = nv_active_empty_voltage_i;
          next_iae = nv_active_empty_current_i;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state <= ST_WAIT_LOAD;
      conv_cnt <= '0;
      bias <= BYTE_RST;
      full40 <= '0;
      ae_frac <= '0;
      sl_full <= '{default: BYTE_RST};
      sl_ae <= '{default: BYTE_RST};
      sl_se <= '{default: BYTE_RST};
      bp <= '{default: BYTE_RST};
      cond <= BYTE_RST;
      full_charge_voltage_threshold <= BYTE_RST;
      active_empty_voltage <= BYTE_RST;
      active_empty_current <= BYTE_RST;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      bias <= next_bias;
      full40 <= next_full40;
      ae_frac <= next_ae_frac;
      sl_full <= next_sl_full;
      sl_ae <= next_sl_ae;
      sl_se <= next_sl_se;
      bp <= next_bp;
      cond <= next_cond;
      full_charge_voltage_threshold <= next_full_charge_voltage_threshold;
      active_empty_voltage <= next_vae;
      active_empty_current <= next_iae;
    end
  end

  // accumulation and odometer
  always_comb begin
    logic [27:0] drop;
    logic [29:0] thr;
    drop = '0;
    thr = '0;
    // R2 bias weighted like one current LSB
    step = $signed({current_i[15], current_i}) + $signed({{9{bias[7]}}, bias});
    // R1 bias enters every accumulation
    sum_wide = $signed({2'b00, acc}) + $signed({{13{step[16]}}, step});
    next_acc = acc;
    next_disch = disch;
    next_odo = odo;
    odo_inc = 1'b0;
    // R12 twice the full value in accumulator units, twelve fraction bits below
    thr = {1'b0, full40, {FRAC_W{1'b0}}, 1'b0};
    if (tick) begin
      // R22 clamp at both ends
      if (sum_wide < 0) begin
        next_acc = ACC_RST;
      end else if (sum_wide > $signed({2'b00, ACC_MAX})) begin
        next_acc = ACC_MAX;
      end else begin
        next_acc = sum_wide[27:0];
      end
      if (next_acc < acc) begin
        drop = acc - next_acc;
      end
      next_disch = disch + 30'(drop[16:0]);
      // R4 R24 two full equivalents per count
      if (thr != '0 && next_disch >= thr) begin
        next_disch = next_disch - thr;
        odo_inc = 1'b1;
      end
    end
    // R5 hold at maximum
    if (odo_inc && odo != ODO_MAX) begin
      next_odo = odo + 8'h01;
    end
    // host write clears the fraction
    if (acr_wr_i) begin
      next_acc = {acr_wdata_i, {FRAC_W{1'b0}}};
    end
    // R6 writable only while unlocked
    if (cycle_wr_i && !block1_locked_i) begin
      next_odo = cycle_wdata_i;
    end
    if (state == ST_WAIT_LOAD && nv_load_i) begin
      next_odo = nv_cycle_count_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      acc <= ACC_RST;
      disch <= '0;
      odo <= BYTE_RST;
    end else begin
      acc <= next_acc;
      disch <= next_disch;
      odo <= next_odo;
    end
  end

  // R9 R11 whole degrees, flat above +40
  assign temp_deg = ($signed(temp_i[10:TEMP_FRAC]) > TEMP_TOP) ? TEMP_TOP : $signed(temp_i[10:TEMP_FRAC]);
  // R13 fraction of full, 2^-10 steps
  assign ae40 = 16'((32'(full40) * 32'(ae_frac)) >> AE_SHIFT);

  cml_curve #(.ADD_SLOPE(1'b0)) u_full (
    .base_i(full40),
    .full40_i(full40),
    .slope_i(sl_full),
    .bp_i(bp),
    .temp_i(temp_deg),
    .value_o(cur_full)
  );
  // empties grow toward cold, so their slopes add
  cml_curve #(.ADD_SLOPE(1'b1)) u_ae (
    .base_i(ae40),
    .full40_i(full40),
    .slope_i(sl_ae),
    .bp_i(bp),
    .temp_i(temp_deg),
    .value_o(cur_ae)
  );
  // R14 standby base fixed at zero
  cml_curve #(.ADD_SLOPE(1'b1)) u_se (
    .base_i(16'h0000),
    .full40_i(full40),
    .slope_i(sl_se),
    .bp_i(bp),
    .temp_i(temp_deg),
    .value_o(cur_se)
  );

  // thresholds and absolute capacity
  always_comb begin
    // R20 average of both cells, 19.5 mV units
    vsum = 11'(first_cell_voltage_i) + 11'(second_cell_voltage_i);
    dis_mag = 17'h00000 - {current_i[15], current_i};
    // R17 full-charge voltage compare
    next_fv = vsum[10:3] >= full_charge_voltage_threshold;
    next_av = vsum[10:3] <= active_empty_voltage;
    next_ac = current_i[15] && (dis_mag >= 17'({active_empty_current, {IAE_SHIFT{1'b0}}}));
    // R16 conductance scales to absolute units
    next_abs = 24'(cur_full * cond);
    next_done = tick;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      full_cap_o <= '0;
      active_empty_cap_o <= '0;
      standby_empty_cap_o <= '0;
      full_abs_o <= '0;
      full_charge_voltage_reached_o <= 1'b0;
      active_empty_voltage_reached_o <= 1'b0;
      active_empty_current_reached_o <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      full_cap_o <= cur_full;
      active_empty_cap_o <= cur_ae;
      standby_empty_cap_o <= cur_se;
      full_abs_o <= next_abs;
      full_charge_voltage_reached_o <= next_fv;
      active_empty_voltage_reached_o <= next_av;
      active_empty_current_reached_o <= next_ac;
      conv_done_o <= next_done;
    end
  end

  assign loaded_o = state;
  assign accumulation_bias_value_o = bias;
  assign charge_accumulator_o = acc[27:FRAC_W];
  assign cycle_count_o = odo;

  sequence s_tick_in_range;
    tick && !acr_wr_i && sum_wide >= 0 && sum_wide <= $signed({2'b00, ACC_MAX});
  endsequence
  sequence s_quiet_after;
    !tick [*8];
  endsequence

  AST_BIAS_ADDED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R1
    s_tick_in_range |=> acc == 28'($past(sum_wide))) else $error("accumulation mismatch");
  AST_SAT_HI: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R22
    (tick && !acr_wr_i && sum_wide > $signed({2'b00, ACC_MAX})) |=> acc == ACC_MAX) else $error("no high clamp");
  AST_SAT_LO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R22
    (tick && !acr_wr_i && sum_wide < 0) |=> acc == ACC_RST) else $error("no low clamp");
  AST_CONV_SPACING: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R21
    tick |=> s_quiet_after) else $error("conversion ticks too close");
  AST_LOAD_BIAS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R3
    (state == ST_WAIT_LOAD && nv_load_i && !bias_wr_i) |=> bias == $past(nv_bias_i)) else $error("bias not loaded");
  AST_ODO_CLAMP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R5
    (odo == ODO_MAX && !cycle_wr_i && state == ST_RUN) |=> odo == ODO_MAX) else $error("odometer wrapped");
  AST_ODO_LOCK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R6
    (block1_locked_i && !odo_inc && state == ST_RUN) |=> odo == $past(odo)) else $error("locked odometer changed");
  AST_ODO_STEP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R24
    (odo_inc && odo != ODO_MAX && !cycle_wr_i && state == ST_RUN) |=> odo == $past(odo) + 8'h01)
    else $error("odometer missed a step");
  AST_FULL_TOP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R7
    (temp_deg == TEMP_TOP) |=> full_cap_o == $past(full40)) else $error("full not flat at top");
  AST_SE_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R14
    (temp_deg == TEMP_TOP) ##1 (temp_deg == TEMP_TOP) |-> standby_empty_cap_o == 16'h0000)
    else $error("standby not zero at top");
endmodule // cml_lookup

// >>> verilog/cml_pkg.sv
package cml_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam longint CONV_PERIOD_NS = 64'h00000000D1CEF200;
  localparam int CONV_CYCLES_DEF = int'(CONV_PERIOD_NS / CLK_PERIOD_NS);
  localparam int N_SEG = 4;
  localparam int N_BP = 3;
  localparam int FRAC_W = 12;
  localparam int SLOPE_SHIFT = 14;
  localparam int AE_SHIFT = 10;
  localparam int TEMP_FRAC = 3;
  localparam int IAE_SHIFT = 7;
  localparam logic signed [7:0] TEMP_TOP = 8'h28;
  localparam logic [27:0] ACC_MAX = 28'hFFFFFFF;
  localparam logic [27:0] ACC_RST = 28'h0000000;
  localparam logic [7:0] ODO_MAX = 8'hFF;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] CAP_MAX = 16'hFFFF;
  localparam logic [31:0] CNT_ONE = 32'h00000001;
  typedef enum logic {
    ST_WAIT_LOAD = 1'b0,
    ST_RUN = 1'b1
  } cml_state_t;
endpackage
